// ### verilog/rx_line_params.svh
`ifndef RX_LINE_PARAMS_SVH
`define RX_LINE_PARAMS_SVH
// ==========================================================
// Constants of the receive line input sampler.
// ==========================================================
// Stages of each pin synchroniser.
`define SYNC_STAGES 3
// Reset level of every synchroniser stage and filtered level.
`define PIN_RESET_LEVEL 1'b0
// Reset value of the sample word.
`define SAMPLE_RESET 3'h0
// Bit positions of the sample word.
`define SAMPLE_DATA_BIT 0
`define SAMPLE_NEG_BIT 1
`define SAMPLE_POS_BIT 2
`endif

// ### verilog/rx_line_pkg.sv
// ==========================================================
// Types and helpers shared by the receive line input stage.
// ==========================================================
package rx_line_pkg;
    // One captured bit period of the line.
    typedef struct packed {
        logic pos_pulse; // Positive line pulse seen (dual-rail only).
        logic neg_pulse; // Negative line pulse seen (dual-rail only).
        logic data;      // Line bit: rail data or pulse present.
    } rx_sample_type;

    // Filtered level: a change counts once stages two and three agree.
    function automatic logic filter_next(input logic s2, input logic s3, input logic cur);
        filter_next = (s2 == s3) ? s3 : cur;
    endfunction
endpackage

// ### verilog/rx_line_input_sampler.sv
// Contract
// R1 - Capture both rails on recovered clock.
// R2 - Receive framer timed by recovered clock only.
// R3 - Option: transmit timing from recovered clock.
// R4 - Single-rail: positive rail is the data.
// R5 - Single-rail: sample on user-selected edge.
// R6 - Single-rail: negative rail ignored, held low.
// R7 - Dual-rail: both rails carry coded signal.
// R8 - Positive rail asserted means positive pulse.
// R9 - Negative rail asserted means negative pulse.
`timescale 1ns/1ps
`include "rx_line_params.svh"

module rx_line_input_sampler
(
    input  wire logic                      core_clk,
    input  wire logic                      rst,
    input  wire logic                      recovered_line_clock,
    input  wire logic                      positive_rail_input,
    input  wire logic                      negative_rail_input,
    input  wire logic                      tx_local_clock,
    input  wire logic                      dual_rail_mode,
    input  wire logic                      sample_on_falling,
    input  wire logic                      tx_loop_timing,
    output logic                           rx_bit_tick,
    output rx_line_pkg::rx_sample_type     rx_sample,
    output logic                           tx_bit_tick
);
    import rx_line_pkg::*;

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    // Each pin passes three stages; stage one feeds stage two only.
    logic [`SYNC_STAGES-1:0] clk_sync_q;  // Recovered clock stages.
    logic [`SYNC_STAGES-1:0] pos_sync_q;  // Positive rail stages.
    logic [`SYNC_STAGES-1:0] neg_sync_q;  // Negative rail stages.
    logic [`SYNC_STAGES-1:0] txc_sync_q;  // Transmit clock stages.

    // Shift each pin in; reset loads a constant level.
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            clk_sync_q <= {`SYNC_STAGES{`PIN_RESET_LEVEL}};
            pos_sync_q <= {`SYNC_STAGES{`PIN_RESET_LEVEL}};
            neg_sync_q <= {`SYNC_STAGES{`PIN_RESET_LEVEL}};
            txc_sync_q <= {`SYNC_STAGES{`PIN_RESET_LEVEL}};
        end
        else
        begin
            clk_sync_q <= {clk_sync_q[1:0], recovered_line_clock};
            pos_sync_q <= {pos_sync_q[1:0], positive_rail_input};
            neg_sync_q <= {neg_sync_q[1:0], negative_rail_input};
            txc_sync_q <= {txc_sync_q[1:0], tx_local_clock};
        end
    end

    // ==========================================================
    // Filtered levels and edge detection
    // ==========================================================
    logic clk_f_q;    // Filtered recovered clock level.
    logic clk_last_q; // Filtered recovered clock, one cycle older.
    logic pos_f_q;    // Filtered positive rail level.
    logic neg_f_q;    // Filtered negative rail level.
    logic txc_f_q;    // Filtered transmit clock level.
    logic txc_last_q; // Filtered transmit clock, one cycle older.

    // Filters read stages two and three, so glitches shorter than
    // a core cycle never become an edge.
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            clk_f_q    <= `PIN_RESET_LEVEL;
            clk_last_q <= `PIN_RESET_LEVEL;
            pos_f_q    <= `PIN_RESET_LEVEL;
            neg_f_q    <= `PIN_RESET_LEVEL;
            txc_f_q    <= `PIN_RESET_LEVEL;
            txc_last_q <= `PIN_RESET_LEVEL;
        end
        else
        begin
            clk_f_q    <= filter_next(clk_sync_q[1], clk_sync_q[2], clk_f_q);
            clk_last_q <= clk_f_q;
            pos_f_q    <= filter_next(pos_sync_q[1], pos_sync_q[2], pos_f_q);
            neg_f_q    <= filter_next(neg_sync_q[1], neg_sync_q[2], neg_f_q);
            txc_f_q    <= filter_next(txc_sync_q[1], txc_sync_q[2], txc_f_q);
            txc_last_q <= txc_f_q;
        end
    end

    // Edges of the filtered clocks.
    wire rise_w    = clk_f_q & ~clk_last_q;
    wire fall_w    = ~clk_f_q & clk_last_q;
    wire tx_rise_w = txc_f_q & ~txc_last_q;

    // Single-rail takes the chosen edge; dual-rail always the rising one.
    wire single_fall_w = ~dual_rail_mode & sample_on_falling;         // [R5]
    wire rx_edge_w     = single_fall_w ? fall_w : rise_w;              // [R2]

    // Transmit timing follows the recovered clock when looped.
    // Loop timing reuses the receive strobe itself, so both framers see the
    // same bit boundary with no extra latency between them.
    wire tx_edge_w = tx_loop_timing ? rx_edge_w : tx_rise_w;          // [R3]

    // ==========================================================
    // Rail decoding
    // ==========================================================
    // Data and rails are delayed exactly like the clock, so the
    // sample sits at the same point relative to the edge as at the pins.
    // Limitation: a rail level must stand over the sampling edge for at
    // least two core cycles, or the agree filter may drop it.
    rx_sample_type sample_w; // Decoded bit period.
    assign sample_w.pos_pulse = dual_rail_mode & pos_f_q;              // [R8]
    assign sample_w.neg_pulse = dual_rail_mode & neg_f_q;              // [R9] [R6]
    // Single-rail takes the positive rail alone; dual-rail marks a pulse.
    assign sample_w.data = dual_rail_mode ? (pos_f_q | neg_f_q) : pos_f_q; // [R4] [R7]

    // ==========================================================
    // Output registers
    // ==========================================================
    rx_sample_type sample_q; // Held sample word.
    logic rx_tick_q;         // Receive framer bit strobe.
    logic tx_tick_q;         // Transmit framer bit strobe.

    // The strobe is registered rather than a regenerated clock, which keeps
    // every framer on the single core clock at the cost of some latency.
    // Capture on the selected edge and hold until the next one.
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            sample_q  <= `SAMPLE_RESET;
            rx_tick_q <= 1'b0;
            tx_tick_q <= 1'b0;
        end
        else
        begin
            if (rx_edge_w)
            begin
                sample_q <= sample_w; // [R1]
            end
            rx_tick_q <= rx_edge_w;
            tx_tick_q <= tx_edge_w;
        end
    end

    assign rx_bit_tick = rx_tick_q;
    assign rx_sample   = sample_q;
    assign tx_bit_tick = tx_tick_q;

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Both rails are captured together at each dual-rail strobe.
    capture_rails_a: assert property ( // [R1]
        rx_tick_q && $past(dual_rail_mode) |->
            sample_q.pos_pulse == $past(pos_f_q) && sample_q.neg_pulse == $past(neg_f_q))
        else $error("Rails not captured at strobe.");

    // A strobe only follows a change of the filtered recovered clock.
    rx_timing_a: assert property ( // [R2]
        rx_tick_q |-> $past(clk_f_q) != $past(clk_last_q))
        else $error("Receive strobe without recovered clock edge.");

    // Looped transmit timing matches the receive strobe.
    tx_loop_a: assert property ( // [R3]
        $past(tx_loop_timing) |-> tx_tick_q == rx_tick_q)
        else $error("Looped transmit strobe differs from receive.");

    // Local transmit timing follows the transmit clock rise.
    tx_local_a: assert property ( // [R3]
        !$past(tx_loop_timing) && tx_tick_q |-> $past(txc_f_q) && !$past(txc_last_q))
        else $error("Local transmit strobe without rising edge.");

    // Single-rail data is the positive rail.
    single_data_a: assert property ( // [R4]
        rx_tick_q && !$past(dual_rail_mode) |-> sample_q.data == $past(pos_f_q))
        else $error("Single-rail data not taken from positive rail.");

    // Single-rail edge is the one the user picked.
    edge_pick_a: assert property ( // [R5]
        rx_tick_q && !$past(dual_rail_mode) |-> $past(clk_f_q) == !$past(sample_on_falling))
        else $error("Single-rail sample on wrong edge.");

    // Single-rail never reports a negative pulse.
    neg_ignored_a: assert property ( // [R6]
        !$past(dual_rail_mode) && rx_tick_q |-> !sample_q.neg_pulse && !sample_q.pos_pulse)
        else $error("Negative rail not ignored in single-rail.");

    // Dual-rail data marks any pulse and uses the rising edge.
    dual_data_a: assert property ( // [R7]
        rx_tick_q && $past(dual_rail_mode) |->
            sample_q.data == ($past(pos_f_q) | $past(neg_f_q)) && $past(clk_f_q))
        else $error("Dual-rail data wrong.");

    // Positive pulse flag is held between strobes.
    pos_hold_a: assert property ( // [R8]
        !rx_tick_q |-> $stable(sample_q))
        else $error("Sample changed between strobes.");

    // Positive pulse appears at the strobe, one cycle after the rising edge.
    pos_pulse_a: assert property ( // [R8]
        $past(rise_w) && $past(dual_rail_mode) && $past(pos_f_q) |-> sample_q.pos_pulse)
        else $error("Positive pulse lost.");

    // Negative pulse appears at the strobe, one cycle after the rising edge.
    neg_pulse_a: assert property ( // [R9]
        $past(rise_w) && $past(dual_rail_mode) && $past(neg_f_q) |-> sample_q.neg_pulse)
        else $error("Negative pulse lost.");

    // A receive strobe never lasts two cycles, as the filter holds each level.
    rx_pulse_a: assert property ( // [R2]
        rx_tick_q |=> !rx_tick_q)
        else $error("Receive strobe longer than one cycle.");

    // A local transmit strobe never lasts two cycles either.
    tx_pulse_a: assert property ( // [R3]
        !$past(tx_loop_timing) && !tx_loop_timing && tx_tick_q |=> !tx_tick_q)
        else $error("Transmit strobe longer than one cycle.");

endmodule

// ### tb/liu_model.sv
`timescale 1ns/1ps
// ==========================================================
// Line interface unit model: recovered clock and two rails.
// ==========================================================
module liu_model
(
    input  wire logic dual_rail,
    output logic      line_clk,
    output logic      pos_rail,
    output logic      neg_rail
);
    // The clock stands low between bits and the rails start low.
    initial
    begin
        line_clk = 1'b0;
        pos_rail = 1'b0;
        neg_rail = 1'b0;
    end
    // One bit of an 80 ns clock period plus a short tail; rails are true only
    // around the chosen edge, inverted elsewhere; in single-rail the negative rail holds until the tail.
    task automatic send_bit(input logic p, input logic n, input logic fall);
        // Start off the core clock edge so no pin change races a sampling edge.
        #2;
        pos_rail = fall ? ~p : p;
        neg_rail = n;
        #40 line_clk = 1'b1;
        #20 pos_rail = fall ? p : ~p;
        neg_rail = dual_rail ? ~n : n;
        #20 line_clk = 1'b0;
        #20 pos_rail = ~p;
        // A released negative rail is pulled low outside dual-rail use.
        neg_rail = dual_rail ? ~n : 1'b0;
    endtask
endmodule

// ### tb/rx_line_input_sampler_tb.sv
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench of the receive line input sampler.
// ==========================================================
module rx_line_input_sampler_tb;
    import rx_line_pkg::*;
    logic          core_clk = 1'b0;          // Core clock.
    logic          rst = 1'b1;               // Synchronous reset.
    logic          tx_local_clock = 1'b0;    // Transmit framer's own clock.
    logic          dual_rail_mode = 1'b0;    // Rail format.
    logic          sample_on_falling = 1'b0; // Single-rail edge choice.
    logic          tx_loop_timing = 1'b0;    // Transmit timing source.
    logic          line_clk;                 // Recovered clock from the model.
    logic          pos_rail;                 // Positive rail from the model.
    logic          neg_rail;                 // Negative rail from the model.
    logic          rx_bit_tick;              // Receive bit strobe.
    logic          tx_bit_tick;              // Transmit bit strobe.
    rx_sample_type rx_sample;                // Captured bit.
    int            n_mismatch = 0;           // Failed comparisons.
    int            samples_checked = 0;      // All comparisons.
    logic          seen;                     // Strobe found within the bound.
    logic          tx_at;                    // Other strobe at that moment.
    // Rows: dual, falling, loop, pos, neg, expected {pos_pulse, neg_pulse, data}.
    logic [7:0]    rows [8] = '{8'h11, 8'h20, 8'h59, 8'h60, 8'h95, 8'hAB, 8'hC0, 8'hF5};

    // ==========================================================
    // Clock, design and partner.
    // ==========================================================
    always #5 core_clk = ~core_clk;
    rx_line_input_sampler dut_u (.core_clk(core_clk), .rst(rst), .recovered_line_clock(line_clk),
        .positive_rail_input(pos_rail), .negative_rail_input(neg_rail), .tx_local_clock(tx_local_clock),
        .dual_rail_mode(dual_rail_mode), .sample_on_falling(sample_on_falling),
        .tx_loop_timing(tx_loop_timing), .rx_bit_tick(rx_bit_tick), .rx_sample(rx_sample),
        .tx_bit_tick(tx_bit_tick));
    liu_model liu_u (.dual_rail(dual_rail_mode), .line_clk(line_clk), .pos_rail(pos_rail),
        .neg_rail(neg_rail));

    // ==========================================================
    // Checking tasks.
    // ==========================================================
    // Four-state compare, so an unknown never counts as a match.
    task automatic compare(input logic [3:0] got, input logic [3:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Single closing point, also taken when a bounded wait runs out.
    task automatic print_verdict();
        $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Sends one bit and waits, bounded, for its strobe; the sample holds after it.
    task automatic run_bit(input logic [7:0] r);
        seen = 1'b0;
        fork
            liu_u.send_bit(r[4], r[3], r[6] & ~r[7]);
            for (int k = 0; k < 30 && !seen; k++)
            begin
                @(posedge core_clk);
                #1;
                seen = (rx_bit_tick === 1'b1);
                tx_at = tx_bit_tick;
            end
        join
        compare({3'h0, seen}, 4'h1);
        compare({1'b0, rx_sample}, {1'b0, r[2:0]});
        compare({3'h0, tx_at}, {3'h0, r[5]});
        if (!seen)
            print_verdict();
    endtask

    // ==========================================================
    // Main sequence: reset, table rows, local transmit timing.
    // ==========================================================
    initial
    begin
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        #1;
        compare({rx_bit_tick, tx_bit_tick, 2'h0}, 4'h0);
        compare({1'b0, rx_sample}, 4'h0);
        foreach (rows[i])
        begin
            // Let the last bit's trailing clock edge pass under the old setting.
            repeat (6) @(posedge core_clk);
            dual_rail_mode <= rows[i][7];
            sample_on_falling <= rows[i][6];
            tx_loop_timing <= rows[i][5];
            repeat (2) @(posedge core_clk);
            run_bit(rows[i]);
        end
        // Local timing: a transmit edge alone must not strobe the receive side.
        @(posedge core_clk);
        tx_loop_timing <= 1'b0;
        tx_local_clock <= 1'b1;
        seen = 1'b0;
        for (int k = 0; k < 20 && !seen; k++)
        begin
            @(posedge core_clk);
            #1;
            seen = (tx_bit_tick === 1'b1);
            tx_at = rx_bit_tick;
        end
        compare({3'h0, seen}, 4'h1);
        compare({3'h0, tx_at}, 4'h0);
        @(posedge core_clk);
        tx_local_clock <= 1'b0;
        print_verdict();
    end
endmodule
